// [verilog/eeprom_pkg.sv]
/*
 * Shared constants of the serial memory access engine: instruction codes,
 * status layout, protection limits, page geometry and write-cycle timing.
 * Assumes a 100 MHz system clock that samples every serial pin.
 */
package eeprom_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int DEPTH = 256;
    localparam int PAGE_BYTES = 16;
    // Instruction codes
    localparam logic [7:0] LATCH_SET_CMD = 8'h06;
    localparam logic [7:0] LATCH_CLEAR_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] READ_CMD = 8'h03;
    localparam logic [7:0] WRITE_CMD = 8'h02;
    // Status byte layout
    localparam logic [3:0] STATUS_TOP = 4'hF;
    localparam int ST_BP_HI = 3;
    localparam int ST_BP_LO = 2;
    localparam int ST_LATCH = 1;
    localparam int ST_BUSY = 0;
    // Protection boundaries and delivery values
    localparam logic [7:0] PROT_QUARTER = 8'hC0;
    localparam logic [7:0] PROT_HALF = 8'h80;
    localparam logic [7:0] PROT_ALL = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [1:0] BP_DELIVERY = 2'h0;
    // Self-timed write cycle
    localparam int CLK_MHZ = 100;
    localparam int WRITE_CYCLE_US = 7000;
    localparam int WRITE_CYCLES = WRITE_CYCLE_US * CLK_MHZ;
endpackage

// [verilog/pin_sync.sv]
/*
 * Two-flop synchroniser bank for asynchronous pins.
 * Assumes the inputs are levels that stay stable for several clocks.
 */
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= INIT;
            q_o <= INIT;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule

// [verilog/write_timer.sv]
/*
 * Self-timed programming cycle counter: a start pulse makes busy high
 * for CYCLES clocks, then a one-cycle done pulse.
 * Assumes start never comes while busy.
 */
`timescale 1ns/10ps
module write_timer #(
    parameter int CYCLES = 700000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);
    logic [31:0] count_reg;

    // Down counter; done marks the last busy cycle ending
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg <= 32'h0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                count_reg <= 32'(CYCLES - 1);
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (count_reg == 32'h0) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    count_reg <= count_reg - 32'h1;
                end
            end
        end
    end
endmodule

// [verilog/spi_eeprom_access_logic.sv]
/*
 * Serial protocol engine of a 256-byte nonvolatile memory: instruction
 * decode, sequential read, byte and page write with protection, status
 * register, self-timed programming cycle.
 * Assumes serial clock, select, data and write-protect arrive asynchronously
 * and are much slower than CLK_I; hold (pause) is not implemented.
 */
`timescale 1ns/10ps
module spi_eeprom_access_logic
    import eeprom_pkg::*;
#(
    parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
    // System
    input wire logic CLK_I,
    input wire logic RST_I,
    // Serial bus pins
    input wire logic SCLK_I,
    input wire logic SEL_N_I,
    input wire logic SDI_I,
    output logic SDO_O,
    output logic SDO_OE_N_O,
    // Write-protect pin
    input wire logic WP_N_I,
    // Status
    output logic WRITE_LATCH_FLAG_O,
    output logic WRITE_BUSY_FLAG_O,
    output logic [1:0] BLOCK_PROTECT_O
);
    // One-hot protocol states; WAIT swallows everything until deselect,
    // which is how rejected, unknown and finished single-byte commands
    // are kept from decoding stray bits as a new instruction.
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_CMD = 6'h02,
        ST_ADDR = 6'h04,
        ST_RDATA = 6'h08,
        ST_WDATA = 6'h10,
        ST_WAIT = 6'h20
    } state_t;

    state_t state_reg;
    logic [3:0] sync_q;
    logic sclk_s, sel_n_s, sdi_s, wp_n_s;
    logic sclk_d_reg, sel_d_reg;
    logic rise, fall, sel_rise;
    logic [7:0] cmd_reg, shift_reg, addr_reg, out_reg;
    logic [2:0] bit_reg;
    logic byte_done;
    logic [7:0] mem_reg [DEPTH];
    logic [7:0] page_reg [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_valid_reg;
    logic [3:0] page_idx_reg;
    logic [7:0] page_base_reg;
    logic armed_reg;
    logic status_pend_reg;
    logic [1:0] bp_reg, bp_new_reg;
    logic latch_reg;
    logic start_wr, busy, done;
    logic prog_status_reg;
    logic protected_page;
    logic [7:0] status_byte;

    // All pins are asynchronous: two flops before any logic
    // Reset values match the idle pins (clock low, deselected, protect off)
    // so that no false edge follows reset.
    pin_sync #(.W(4), .INIT(4'h5)) u_sync (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i({SCLK_I, SEL_N_I, SDI_I, WP_N_I}),
        .q_o(sync_q)
    );
    assign sclk_s = sync_q[3];
    assign sel_n_s = sync_q[2];
    assign sdi_s = sync_q[1];
    assign wp_n_s = sync_q[0];

    // Edge detection on the synchronised copies
    // Limitation: serial clock phases must last several system clocks,
    // otherwise an edge is lost in the synchroniser.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sclk_d_reg <= 1'b0;
            sel_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= sclk_s;
            sel_d_reg <= sel_n_s;
        end
    end
    assign rise = sclk_s && !sclk_d_reg && !sel_n_s;
    assign fall = !sclk_s && sclk_d_reg && !sel_n_s;
    assign sel_rise = sel_n_s && !sel_d_reg;
    assign byte_done = rise && (bit_reg == 3'h7);

    assign status_byte = {STATUS_TOP, bp_reg, latch_reg, busy};

    // Protected when the page base falls at or above the protected floor
    // Boundaries are page aligned, so the base decides for the whole page;
    // this keeps the check off the per-byte path.
    always_comb begin
        unique case (bp_reg)
            2'h0: protected_page = 1'b0;
            2'h1: protected_page = page_base_reg >= PROT_QUARTER;
            2'h2: protected_page = page_base_reg >= PROT_HALF;
            default: protected_page = page_base_reg >= PROT_ALL;
        endcase
    end

    // Programming starts only when select rises right after a full byte
    // with no further rising clock in between.
    assign start_wr = sel_rise && armed_reg && (bit_reg == 3'h0) && !busy
        && latch_reg && (status_pend_reg || (!protected_page && |page_valid_reg));

    write_timer #(.CYCLES(WRITE_CYCLES_P)) u_timer (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .start_i(start_wr),
        .busy_o(busy),
        .done_o(done)
    );

    // Bit counter and input shifter, MSB first
    // Counter clears on deselect so every frame starts byte aligned.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            bit_reg <= 3'h0;
            shift_reg <= 8'h0;
        end else if (sel_n_s) begin
            bit_reg <= 3'h0;
        end else if (rise) begin
            bit_reg <= bit_reg + 3'h1;
            shift_reg <= {shift_reg[6:0], sdi_s};
        end
    end

    // Protocol state machine
    // Opcode is decoded from the shifter plus the bit arriving now, so the
    // decision lands on the same clock as the eighth rising edge.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg <= ST_IDLE;
            cmd_reg <= 8'h0;
        end else if (sel_n_s) begin
            state_reg <= ST_IDLE;
        end else if (byte_done) begin
            unique case (state_reg)
                ST_IDLE, ST_CMD: begin
                    cmd_reg <= {shift_reg[6:0], sdi_s};
                    unique case ({shift_reg[6:0], sdi_s})
                        LATCH_SET_CMD, LATCH_CLEAR_CMD: state_reg <= ST_WAIT;
                        STATUS_READ_CMD: state_reg <= ST_RDATA;
                        STATUS_WRITE_CMD: state_reg <= busy ? ST_WAIT : ST_WDATA;
                        READ_CMD, WRITE_CMD: state_reg <= busy ? ST_WAIT : ST_ADDR;
                        default: state_reg <= ST_WAIT;
                    endcase
                end
                ST_ADDR: state_reg <= (cmd_reg == READ_CMD) ? ST_RDATA : ST_WDATA;
                ST_RDATA: state_reg <= (cmd_reg == STATUS_READ_CMD) ? ST_WAIT : ST_RDATA;
                ST_WDATA: state_reg <= (cmd_reg == STATUS_WRITE_CMD) ? ST_WAIT : ST_WDATA;
                ST_WAIT: state_reg <= ST_WAIT;
            endcase
        end else if (rise && state_reg == ST_IDLE) begin
            state_reg <= ST_CMD;
        end
    end

    // Address counter: read increments with full wrap, write wraps in page
    // Natural 8-bit overflow gives the wrap to zero for free.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            addr_reg <= 8'h0;
        end else if (byte_done && state_reg == ST_ADDR) begin
            addr_reg <= {shift_reg[6:0], sdi_s};
        end else if (byte_done && state_reg == ST_RDATA && cmd_reg == READ_CMD) begin
            addr_reg <= addr_reg + 8'h1;
        end
    end

    // Output shifter: array bytes load on the falling clock that opens a
    // byte, so the last bit of the previous byte stands through its rising
    // edge; loading at the rising edge would move the pin while clock high.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            out_reg <= 8'hFF;
        end else if (state_reg == ST_CMD && byte_done) begin
            out_reg <= status_byte;
        end else if (state_reg == ST_RDATA && fall && bit_reg == 3'h0 && cmd_reg == READ_CMD) begin
            out_reg <= mem_reg[addr_reg];
        end else if (state_reg == ST_RDATA && fall && bit_reg != 3'h0) begin
            out_reg <= {out_reg[6:0], 1'b1};
        end
    end

    // Serial output pin; released whenever not reading
    // Released pin keeps the last bit shifted; reset and each opcode byte return it to one.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            SDO_O <= 1'b1;
            SDO_OE_N_O <= 1'b1;
        end else begin
            SDO_O <= out_reg[7];
            SDO_OE_N_O <= !(state_reg == ST_RDATA && !sel_n_s);
        end
    end

    // Page buffer capture; later bytes past the page end overwrite
    // Buffer is cleared at each new frame start unless a cycle is running,
    // so the buffer being programmed is never disturbed.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            page_valid_reg <= '0;
            page_idx_reg <= 4'h0;
            page_base_reg <= 8'h0;
            status_pend_reg <= 1'b0;
            bp_new_reg <= BP_DELIVERY;
            armed_reg <= 1'b0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                page_reg[i] <= ERASED_BYTE;
            end
        end else if (state_reg == ST_IDLE && !sel_n_s && !busy) begin
            page_valid_reg <= '0;
            status_pend_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else if (rise) begin
            armed_reg <= 1'b0;
            if (byte_done && state_reg == ST_ADDR && cmd_reg == WRITE_CMD) begin
                page_idx_reg <= sdi_s ? {shift_reg[2:0], 1'b1} : {shift_reg[2:0], 1'b0};
                page_base_reg <= {shift_reg[6:3], 4'h0};
            end else if (byte_done && state_reg == ST_WDATA) begin
                armed_reg <= 1'b1;
                if (cmd_reg == STATUS_WRITE_CMD) begin
                    bp_new_reg <= {shift_reg[2], shift_reg[1]};
                    status_pend_reg <= 1'b1;
                end else begin
                    page_reg[page_idx_reg] <= {shift_reg[6:0], sdi_s};
                    page_valid_reg[page_idx_reg] <= 1'b1;
                    page_idx_reg <= page_idx_reg + 4'h1;
                end
            end
        end
    end

    // Array storage; delivered erased, committed after the timed cycle
    // Only bytes actually received are written; the rest keep their value.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= ERASED_BYTE;
            end
        end else if (done && !prog_status_reg) begin
            for (int j = 0; j < PAGE_BYTES; j++) begin
                if (page_valid_reg[j]) begin
                    mem_reg[page_base_reg | 8'(j)] <= page_reg[j];
                end
            end
        end
    end

    // Protect bits; updated only when a status cycle completes
    // Old bits stay visible during the cycle, as status reads expect.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            bp_reg <= BP_DELIVERY;
            prog_status_reg <= 1'b0;
        end else begin
            if (start_wr) begin
                prog_status_reg <= status_pend_reg;
            end
            if (done && prog_status_reg) begin
                bp_reg <= bp_new_reg;
            end
        end
    end

    // Write-enable latch
    // Clear sources win over the set; protect pin is ignored while busy
    // because a running cycle must finish and clears the latch anyway.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            latch_reg <= 1'b0;
        end else if (!wp_n_s && !busy) begin
            latch_reg <= 1'b0;
        end else if (done) begin
            latch_reg <= 1'b0;
        end else if (byte_done && (state_reg == ST_CMD) && !busy) begin
            if ({shift_reg[6:0], sdi_s} == LATCH_SET_CMD) begin
                latch_reg <= 1'b1;
            end else if ({shift_reg[6:0], sdi_s} == LATCH_CLEAR_CMD) begin
                latch_reg <= 1'b0;
            end
        end
    end

    // Status outputs
    // Registered copies: one clock behind the internal state.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            WRITE_LATCH_FLAG_O <= 1'b0;
            WRITE_BUSY_FLAG_O <= 1'b0;
            BLOCK_PROTECT_O <= BP_DELIVERY;
        end else begin
            WRITE_LATCH_FLAG_O <= latch_reg;
            WRITE_BUSY_FLAG_O <= busy;
            BLOCK_PROTECT_O <= bp_reg;
        end
    end
    // Glitches on select with no clock reset the framing and drop buffered write data; one right after a full write byte starts programming.
endmodule

// [bench/spi_host_model.sv]
/*
 * Host side of the serial link: drives select, clock and data in, captures data out.
 * Assumes each call starts 1 ns after a system clock edge; delays keep that phase.
 */
`timescale 1ns/10ps
module spi_host_model (
    // Serial pins
    output logic sclk_o,
    output logic sel_n_o,
    output logic sdi_o,
    input wire logic sdo_i,
    input wire logic oe_n_i
);
    // Idle bus: clock parked low, deselected
    initial begin
        sclk_o = 1'b0;
        sel_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    // Gap before select keeps frames apart
    task automatic start();
        #200 sel_n_o = 1'b0;
        #100;
    endtask
    // Released output reads X, so a silent device never matches data
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sdi_o = tx[i];
            #80 sclk_o = 1'b1;
            rx[i] = oe_n_i ? 1'bx : sdo_i;
            #80 sclk_o = 1'b0;
        end
    endtask
    // One extra clock pulse
    task automatic pulse();
        #80 sclk_o = 1'b1;
        #80 sclk_o = 1'b0;
    endtask
    // Deselect before the next rise; data line toggles so no stale level lingers
    task automatic stop();
        #40 sel_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #160;
    endtask
endmodule

// [bench/spi_eeprom_access_logic_checker.sv]
/*
 * Concurrent checks on the ports of the serial memory engine.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/10ps
module spi_eeprom_access_logic_checker #(
    parameter int WRITE_CYCLES_P = 200
) (
    // System
    input wire logic CLK_I,
    input wire logic RST_I,
    // Serial pins
    input wire logic SCLK_I,
    input wire logic SEL_N_I,
    input wire logic SDI_I,
    input wire logic SDO_O,
    input wire logic SDO_OE_N_O,
    // Protect pin and status
    input wire logic WP_N_I,
    input wire logic WRITE_LATCH_FLAG_O,
    input wire logic WRITE_BUSY_FLAG_O,
    input wire logic [1:0] BLOCK_PROTECT_O
);
    int busy_cnt;
    // Length of the current busy stretch
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= WRITE_BUSY_FLAG_O ? busy_cnt + 1 : 0;
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    oe_off_a: assert property (SEL_N_I [*6] |-> SDO_OE_N_O)
        else $error("output driven while deselected");
    oe_sel_a: assert property ($fell(SDO_OE_N_O) |-> !SEL_N_I && !$past(SEL_N_I, 8))
        else $error("output enabled without a running frame");
    sdo_fall_a: assert property ($changed(SDO_O) && !SDO_OE_N_O && !$past(SDO_OE_N_O, 2) |-> !SCLK_I)
        else $error("read data changed while clock high");
    busy_len_a: assert property ($fell(WRITE_BUSY_FLAG_O) |-> $past(busy_cnt) >= WRITE_CYCLES_P - 1 &&
        $past(busy_cnt) <= WRITE_CYCLES_P + 1)
        else $error("programming cycle length wrong");
    latch_end_a: assert property ($fell(WRITE_BUSY_FLAG_O) |-> ##[0:2] !WRITE_LATCH_FLAG_O)
        else $error("latch still set after cycle");
    busy_latch_a: assert property ($rose(WRITE_BUSY_FLAG_O) |-> WRITE_LATCH_FLAG_O)
        else $error("cycle started without latch");
    busy_desel_a: assert property ($rose(WRITE_BUSY_FLAG_O) |-> SEL_N_I && $past(SEL_N_I, 2))
        else $error("cycle started while selected");
    latch_wp_a: assert property ((!WP_N_I && !WRITE_BUSY_FLAG_O) [*5] |-> !WRITE_LATCH_FLAG_O)
        else $error("latch set while protect pin low");
    bp_hold_a: assert property (!$stable(BLOCK_PROTECT_O) |-> $past(WRITE_BUSY_FLAG_O, 2))
        else $error("protect bits changed outside a cycle");
endmodule

// [bench/spi_eeprom_access_logic_tb_top.sv]
/*
 * Self-checking bench of the serial memory engine with a host model.
 * Assumes a 100 MHz clock and a shortened programming cycle.
 */
`timescale 1ns/10ps
module spi_eeprom_access_logic_tb_top;
    import eeprom_pkg::*;
    localparam int WC = 2000;
    logic clk, rst, wp_n, sclk, sel_n, sdi, sdo, oe_n, latch, busy;
    logic [1:0] bp;
    logic [7:0] mem [256];
    logic [7:0] rx, a;
    logic [7:0] pa [4] = '{8'h7F, 8'h80, 8'hBF, 8'hC0};
    int err_count, num_checks;
    spi_eeprom_access_logic #(.WRITE_CYCLES_P(WC)) dut_u (.CLK_I(clk), .RST_I(rst), .SCLK_I(sclk),
        .SEL_N_I(sel_n), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_N_O(oe_n), .WP_N_I(wp_n),
        .WRITE_LATCH_FLAG_O(latch), .WRITE_BUSY_FLAG_O(busy), .BLOCK_PROTECT_O(bp));
    spi_host_model host_u (.sclk_o(sclk), .sel_n_o(sel_n), .sdi_o(sdi), .sdo_i(sdo), .oe_n_i(oe_n));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic bit allowed(input logic [7:0] ad, input logic [1:0] p);
        case (p)
            2'h0: return 1'b1;
            2'h1: return ad < PROT_QUARTER;
            2'h2: return ad < PROT_HALF;
            default: return 1'b0;
        endcase
    endfunction
    task automatic wait_idle();
        for (int i = 0; i < WC + 100 && busy !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        if (busy !== 1'b0) err_count++;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] b);
        host_u.start();
        host_u.xfer(c, rx);
        host_u.xfer(b, rx);
        host_u.stop();
    endtask
    // Four-byte frame whose last byte must find the output released
    task automatic rej(input logic [7:0] c1, input logic [7:0] c2);
        host_u.start();
        host_u.xfer(c1, rx);
        host_u.xfer(c2, rx);
        host_u.xfer(8'h00, rx);
        host_u.xfer(8'h00, rx);
        host_u.stop();
        check("ignored frame", rx, 8'hXX);
    endtask
    task automatic rd(input logic [7:0] ad, input int n);
        host_u.start();
        host_u.xfer(READ_CMD, rx);
        host_u.xfer(ad, rx);
        for (int i = 0; i < n; i++) begin
            host_u.xfer(8'($urandom), rx);
            check("read byte", rx, mem[8'(ad + i)]);
        end
        host_u.stop();
    endtask
    // Expected image only moves when the cycle is really due to start
    task automatic wr(input logic [7:0] ad, input int n, input bit ok, input bit extra);
        logic [7:0] d;
        host_u.start();
        host_u.xfer(WRITE_CMD, rx);
        host_u.xfer(ad, rx);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            host_u.xfer(d, rx);
            if (ok && !extra) mem[{ad[7:4], ad[3:0] + 4'(i)}] = d;
        end
        if (extra) host_u.pulse();
        host_u.stop();
        check("busy after write", 8'(busy), 8'(ok && !extra));
    endtask
    task automatic wrap_up();
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // 100 MHz system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard well beyond the expected run
    initial begin
        #1000000;
        err_count++;
        wrap_up();
    end
    // Main sequence
    initial begin
        void'($urandom(32'hEC88));
        err_count = 0;
        num_checks = 0;
        wp_n = 1'b1;
        rst = 1'b1;
        for (int i = 0; i < 256; i++) mem[i] = ERASED_BYTE;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        check("latch", 8'(latch), 8'h00);
        check("protect", 8'(bp), 8'(BP_DELIVERY));
        check("output released", 8'(oe_n), 8'h01);
        cmd(STATUS_READ_CMD, 8'h00);
        check("status", rx, {STATUS_TOP, 4'h0});
        rd(8'($urandom), 3);
        wr(8'h35, 1, 1'b0, 1'b0);
        rej(LATCH_SET_CMD, READ_CMD);
        check("latch set", 8'(latch), 8'h01);
        cmd(LATCH_CLEAR_CMD, 8'h00);
        check("latch clear", 8'(latch), 8'h00);
        rej(8'hA5, READ_CMD);
        cmd(LATCH_SET_CMD, 8'h00);
        a = {4'($urandom), 4'h3};
        wr(a, 17, 1'b1, 1'b0);
        cmd(STATUS_READ_CMD, 8'h00);
        check("status busy", rx, {STATUS_TOP, 4'h3});
        rej(READ_CMD, a);
        wait_idle();
        check("latch after cycle", 8'(latch), 8'h00);
        rd({a[7:4], 4'h0}, 20);
        rd(8'hFE, 4);
        cmd(LATCH_SET_CMD, 8'h00);
        wr(8'h40, 1, 1'b1, 1'b1);
        wp_n = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        check("latch under protect pin", 8'(latch), 8'h00);
        wp_n = 1'b1;
        rd(8'h40, 1);
        host_u.start();
        host_u.xfer(READ_CMD, rx);
        host_u.xfer(8'h10, rx);
        repeat (3) host_u.pulse();
        host_u.stop();
        check("abort releases output", 8'(oe_n), 8'h01);
        for (int p = 1; p < 4; p++) begin
            cmd(LATCH_SET_CMD, 8'h00);
            cmd(STATUS_WRITE_CMD, {4'h0, 2'(p), 2'h0});
            wait_idle();
            check("protect bits", 8'(bp), 8'(p));
            for (int j = 0; j < 4; j++) begin
                cmd(LATCH_SET_CMD, 8'h00);
                wr(pa[j], 1, allowed(pa[j], 2'(p)), 1'b0);
                wait_idle();
                rd(pa[j], 1);
            end
        end
        wrap_up();
    end
endmodule
bind spi_eeprom_access_logic spi_eeprom_access_logic_checker #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) chk_u (
    .CLK_I(CLK_I), .RST_I(RST_I), .SCLK_I(SCLK_I), .SEL_N_I(SEL_N_I), .SDI_I(SDI_I), .SDO_O(SDO_O),
    .SDO_OE_N_O(SDO_OE_N_O), .WP_N_I(WP_N_I), .WRITE_LATCH_FLAG_O(WRITE_LATCH_FLAG_O),
    .WRITE_BUSY_FLAG_O(WRITE_BUSY_FLAG_O), .BLOCK_PROTECT_O(BLOCK_PROTECT_O));
